// [bench/tb_mac_int_ack_and_mode_control.sv]
// Self-checking bench for the interrupt acknowledge and MAC config block.
`timescale 1ns/1ps
`include "mic_consts.svh"
module tb_mac_int_ack_and_mode_control;
import mic_pkg::*;
logic clk = 1'b0;
logic resetn = 1'b0;
mic_addr_t io_addr = 8'h00;
mic_word_t io_wdata = 16'h0000;
mic_word_t io_rdata;
mic_word_t rx_len = 16'h0000;
mic_gap_t gap;
logic [9:0] evt = 10'h000;
logic io_rd = 1'b0, io_wr = 1'b0, taken = 1'b0, tx_rst = 1'b0, rx_rst = 1'b0;
logic pause_f = 1'b0, crc_v = 1'b0, crc_b = 1'b0, len_v = 1'b0;
logic rvalid, irq, dup, defer, cl_en, longf, p_on, p_start, p_data, keep, strip, crc_e, buf_lb, mac_lb, tl, tl_v;
int n_fail = 0;
int num_checks = 0;

always #4 clk = ~clk;

mic_top i_dut (.clk(clk), .resetn(resetn), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(rvalid),
    .evt_host_bus_fault(evt[0]), .evt_tx_frame_done(evt[1]), .evt_control_frame_seen(evt[2]),
    .evt_rx_frame_in_fifo(evt[3]), .evt_software_interrupt(evt[4]), .evt_counter_near_overflow(evt[5]),
    .evt_link_change(evt[6]), .evt_tx_transfer_done(evt[7]), .evt_rx_transfer_done(evt[8]),
    .evt_modem_line_event(evt[9]), .rx_dma_frame_taken(taken), .tx_path_reset(tx_rst),
    .rx_path_reset(rx_rst), .rx_pause_frame_seen(pause_f), .rx_crc_check_valid(crc_v), .rx_crc_bad(crc_b),
    .rx_len_valid(len_v), .rx_frame_len(rx_len), .interrupt_line(irq), .gap_select(gap),
    .duplex_full_on(dup), .tx_defer_to_rx(defer), .carrier_loss_count_en(cl_en), .long_frame_accept(longf),
    .pause_honor_on(p_on), .pause_start(p_start), .pause_as_data(p_data), .keep_checksum(keep),
    .strip_checksum(strip), .crc_error(crc_e), .buffer_loopback(buf_lb),
    .controller_side_loopback(mac_lb), .frame_too_long_flag(tl), .too_long_valid(tl_v));

task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
        $display("Run complete: PASS");
    end else begin
        $display("Run complete: FAIL");
    end
    $finish;
endtask

task automatic chk(input mic_word_t got, input mic_word_t exp);
    num_checks++;
    if (got !== exp) begin
        n_fail++;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
endtask

task automatic chkb(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
endtask

task automatic cyc(input int n);
    repeat (n) @(negedge clk);
endtask

task automatic wr(input mic_addr_t a, input mic_word_t d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    cyc(1);
    io_wr = 1'b0;
endtask

task automatic rd(input mic_addr_t a, input mic_word_t exp);
    io_addr = a;
    io_rd = 1'b1;
    cyc(1);
    io_rd = 1'b0;
    chkb(rvalid, 1'b1);
    chk(io_rdata, exp);
endtask

task automatic ev(input logic [9:0] m);
    evt = m;
    cyc(1);
    evt = 10'h000;
endtask

task automatic paths(input logic t, input logic r);
    tx_rst = t;
    rx_rst = r;
    cyc(1);
    tx_rst = 1'b0;
    rx_rst = 1'b0;
    cyc(1);
endtask

// Reset values, read-only inversions and an unmapped address.
task automatic t_reset();
    rd(`MIC_OFF_CFG, 16'h0000);
    rd(`MIC_OFF_CAUSE, 16'h0000);
    rd(8'h60, 16'h0000);
    chkb(defer, 1'b1);
    chkb(cl_en, 1'b1);
    chkb(strip, 1'b1);
endtask

// Acknowledge read returns all causes, clears five of them and the mask.
task automatic t_ack();
    wr(`MIC_OFF_MASK, 16'hFFFF);
    rd(`MIC_OFF_MASK, 16'h0FDE);
    ev(10'h3FF);
    chkb(irq, 1'b1);
    rd(`MIC_OFF_ACK, 16'h0FDF);
    chkb(irq, 1'b0);
    rd(`MIC_OFF_CAUSE, 16'h0896);
    rd(`MIC_OFF_MASK, 16'h0000);
    ev(10'h001);
    chkb(irq, 1'b0);
    wr(`MIC_OFF_CAUSE, 16'hFFFF);
    rd(`MIC_OFF_CAUSE, 16'h0010);
    taken = 1'b1;
    cyc(1);
    taken = 1'b0;
    rd(`MIC_OFF_CAUSE, 16'h0000);
    wr(`MIC_OFF_MASK, 16'h0002);
    ev(10'h002);
    chkb(irq, 1'b0);
    ev(10'h001);
    chkb(irq, 1'b1);
    rd(`MIC_OFF_ACK, 16'h0007);
    rd(`MIC_OFF_CAUSE, 16'h0006);
    wr(`MIC_OFF_CAUSE, 16'h0006);
    io_addr = `MIC_OFF_ACK;
    io_rd = 1'b1;
    evt = 10'h040;
    cyc(1);
    io_rd = 1'b0;
    evt = 10'h000;
    chk(io_rdata, 16'h0000);
    rd(`MIC_OFF_CAUSE, 16'h0100);
    wr(`MIC_OFF_CAUSE, 16'h0100);
endtask

// Config fields, duplex held back until both path resets, and loopbacks applied after them.
task automatic t_cfg();
    for (int g = 0; g < 4; g++) begin
        wr(`MIC_OFF_CFG, 16'(g));
        chk({14'h0000, gap}, 16'(g));
    end
    wr(`MIC_OFF_CFG, 16'hFFFF);
    rd(`MIC_OFF_CFG, 16'h0F63);
    chkb(longf, 1'b1);
    chkb(p_on, 1'b1);
    chkb(keep, 1'b1);
    chkb(strip, 1'b0);
    chkb(dup, 1'b0);
    paths(1'b1, 1'b0);
    chkb(dup, 1'b0);
    paths(1'b0, 1'b1);
    chkb(dup, 1'b1);
    chkb(defer, 1'b0);
    chkb(cl_en, 1'b0);
    chkb(buf_lb, 1'b1);
    chkb(mac_lb, 1'b1);
    wr(`MIC_OFF_CFG, 16'h0000);
    chkb(dup, 1'b1);
    paths(1'b1, 1'b1);
    chkb(dup, 1'b0);
    chkb(buf_lb, 1'b0);
    chkb(mac_lb, 1'b0);
    wr(`MIC_OFF_CFG, 16'h0020);
    paths(1'b1, 1'b1);
    chkb(dup, 1'b1);
    chkb(buf_lb, 1'b0);
    chkb(mac_lb, 1'b0);
    wr(`MIC_OFF_CFG, 16'h0000);
    paths(1'b1, 1'b1);
    chkb(defer, 1'b1);
endtask

// Oversize threshold at both settings, one below and at the limit.
task automatic t_len();
    mic_word_t lens [4];
    lens = '{16'h05E9, 16'h05EA, 16'h118A, 16'h118B};
    for (int i = 0; i < 4; i++) begin
        wr(`MIC_OFF_CFG, (i > 1) ? 16'h0040 : 16'h0000);
        rx_len = lens[i];
        len_v = 1'b1;
        cyc(1);
        len_v = 0;
        chkb(tl_v, 1'b1);
        chkb(tl, i[0]);
    end
endtask

// Pause frame handling and checksum errors with both keep settings.
task automatic t_pause();
    for (int k = 0; k < 2; k++) begin
        wr(`MIC_OFF_CFG, (k == 1) ? 16'h0320 : 16'h0000);
        chkb(strip, k == 0);
        pause_f = 1'b1;
        cyc(1);
        pause_f = 1'b0;
        chkb(p_start, k == 1);
        chkb(p_data, k == 0);
        crc_v = 1'b1;
        crc_b = 1'b1;
        cyc(1);
        crc_b = 1'b0;
        chkb(crc_e, 1'b1);
        cyc(1);
        crc_v = 1'b0;
        chkb(crc_e, 1'b0);
    end
endtask

initial begin
    #100000;
    n_fail++;
    wrap_up();
end

initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    cyc(1);
    t_reset();
    t_ack();
    t_cfg();
    t_len();
    t_pause();
    wrap_up();
end

endmodule // tb_mac_int_ack_and_mode_control

// [verilog/mic_consts.svh]
// Offsets, field positions, reset values and thresholds of the interrupt-acknowledge and MAC config block.
// Behaviour
// - Ack alias read returns current cause value.
// - Ack read clears five listed cause bits.
// - Ack read clears whole interrupt enable mask.
// - Alias bit layout; bits 12-15 reserved.
// - Gap select sets post-collision deferral gap.
// - Full duplex stops deferring to receive.
// - Full duplex stops carrier loss counting.
// - Duplex change waits for both path resets.
// - Oversize threshold 1514, or 4491 when long.
// - Compared length covers addresses, type, checksum.
// - Pause frames honoured only when enabled.
// - Keep checksum passes it, else stripped.
// - Checksum checking independent of keep bit.
// - Buffer loopback joins transmit to receive FIFO.
// - Controller loopback joins MAC tx to rx.
// - Pending flag is masked OR, equals line.
// - Writing one clears an ordinary cause bit.
// - Receive DMA clears rx frame in FIFO.
`ifndef MIC_CONSTS_SVH
`define MIC_CONSTS_SVH

`define MIC_OFF_MASK 8'h4C
`define MIC_OFF_ACK 8'h4A
`define MIC_OFF_CAUSE 8'h4E
`define MIC_OFF_CFG 8'h50

`define MIC_B_PEND 0
`define MIC_B_HOSTF 1
`define MIC_B_TXDONE 2
`define MIC_B_CTRLF 3
`define MIC_B_RXFIFO 4
`define MIC_B_SWI 6
`define MIC_B_NEAROVF 7
`define MIC_B_LINK 8
`define MIC_B_TXDMA 9
`define MIC_B_RXDMA 10
`define MIC_B_MODEM 11

`define MIC_ACK_CLR 16'h0748
`define MIC_CAUSE_IMPL 16'h0FDE
`define MIC_CAUSE_W1C 16'h0FCE
`define MIC_CFG_IMPL 16'h0F63

`define MIC_C_GAP_LO 0
`define MIC_C_GAP_HI 1
`define MIC_C_DUPLEX 5
`define MIC_C_LONG 6
`define MIC_C_PAUSE 8
`define MIC_C_KEEP 9
`define MIC_C_BUFLB 10
`define MIC_C_MACLB 11

`define MIC_RST_WORD 16'h0000
`define MIC_LEN_STD 16'h05EA
`define MIC_LEN_LONG 16'h118B

`endif

// [verilog/mic_oversize.sv]
// Oversize frame check against the standard or long-frame threshold, chosen by long_frame_accept.
`timescale 1ns/1ps
`include "mic_consts.svh"
module mic_oversize (
    input wire logic clk,
    input wire logic resetn,
    input wire logic long_frame_accept,
    input wire logic rx_len_valid,
    input wire mic_pkg::mic_word_t rx_frame_len,
    output logic frame_too_long_flag,
    output logic too_long_valid
);
    import mic_pkg::*;

    mic_ovs_t st_reg;
    mic_ovs_t st_next;
    mic_word_t limit;

    always_comb begin
        limit = long_frame_accept ? `MIC_LEN_LONG : `MIC_LEN_STD;
        st_next.valid = rx_len_valid;
        st_next.flag = rx_len_valid && (rx_frame_len >= limit);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign frame_too_long_flag = st_reg.flag;
    assign too_long_valid = st_reg.valid;

    a_oversize_limit: assert property (@(posedge clk) disable iff (!resetn)
        rx_len_valid |=> frame_too_long_flag ==
        ($past(rx_frame_len) >= ($past(long_frame_accept) ? 16'h118B : 16'h05EA)))
        else $error("oversize flag does not match threshold");

endmodule // mic_oversize

// [verilog/mic_pkg.sv]
// Types shared by the interrupt-acknowledge and MAC config block.
package mic_pkg;

typedef logic [15:0] mic_word_t;
typedef logic [7:0] mic_addr_t;
typedef logic [1:0] mic_gap_t;

typedef struct packed {
    logic [15:0] cause;
    logic [15:0] mask;
    logic [15:0] cfg;
    logic irq;
    logic [15:0] rdata;
    logic rvalid;
    logic eff_duplex;
    logic eff_buf_lb;
    logic eff_mac_lb;
    logic seen_tx;
    logic seen_rx;
    logic pause_start;
    logic pause_as_data;
    logic crc_error;
    logic tx_defer;
    logic carrier_en;
    logic strip_fcs;
} mic_state_t;

typedef struct packed {
    logic flag;
    logic valid;
} mic_ovs_t;

endpackage

// [verilog/mic_top.sv]
// Interrupt cause, acknowledge alias, interrupt mask and MAC config register block.
`timescale 1ns/1ps
`include "mic_consts.svh"
module mic_top (
    input wire logic clk,
    input wire logic resetn,
    input wire mic_pkg::mic_addr_t io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire mic_pkg::mic_word_t io_wdata,
    output mic_pkg::mic_word_t io_rdata,
    output logic io_rdata_valid,
    input wire logic evt_host_bus_fault,
    input wire logic evt_tx_frame_done,
    input wire logic evt_control_frame_seen,
    input wire logic evt_rx_frame_in_fifo,
    input wire logic evt_software_interrupt,
    input wire logic evt_counter_near_overflow,
    input wire logic evt_link_change,
    input wire logic evt_tx_transfer_done,
    input wire logic evt_rx_transfer_done,
    input wire logic evt_modem_line_event,
    input wire logic rx_dma_frame_taken,
    input wire logic tx_path_reset,
    input wire logic rx_path_reset,
    input wire logic rx_pause_frame_seen,
    input wire logic rx_crc_check_valid,
    input wire logic rx_crc_bad,
    input wire logic rx_len_valid,
    input wire mic_pkg::mic_word_t rx_frame_len,
    output logic interrupt_line,
    output mic_pkg::mic_gap_t gap_select,
    output logic duplex_full_on,
    output logic tx_defer_to_rx,
    output logic carrier_loss_count_en,
    output logic long_frame_accept,
    output logic pause_honor_on,
    output logic pause_start,
    output logic pause_as_data,
    output logic keep_checksum,
    output logic strip_checksum,
    output logic crc_error,
    output logic buffer_loopback,
    output logic controller_side_loopback,
    output logic frame_too_long_flag,
    output logic too_long_valid
);
    import mic_pkg::*;

    localparam mic_state_t ST_RESET = '{tx_defer: 1'b1, carrier_en: 1'b1, strip_fcs: 1'b1, default: '0};
    mic_state_t st_reg;
    mic_state_t st_next;
    mic_word_t set_vec;
    mic_word_t clr_vec;
    logic rd_ack;
    logic rd_cause;
    logic rd_mask;
    logic rd_cfg;
    logic wr_cause;
    logic wr_mask;
    logic wr_cfg;

    function automatic logic hit(input mic_addr_t a, input mic_addr_t off);
        hit = (a == off);
    endfunction

    function automatic mic_word_t cause_view(input mic_word_t c, input logic p);
        cause_view = (c & `MIC_CAUSE_IMPL) | {15'h0000, p};
    endfunction

    always_comb begin
        rd_ack = io_rd && hit(io_addr, `MIC_OFF_ACK);
        rd_cause = io_rd && hit(io_addr, `MIC_OFF_CAUSE);
        rd_mask = io_rd && hit(io_addr, `MIC_OFF_MASK);
        rd_cfg = io_rd && hit(io_addr, `MIC_OFF_CFG);
        wr_cause = io_wr && hit(io_addr, `MIC_OFF_CAUSE);
        wr_mask = io_wr && hit(io_addr, `MIC_OFF_MASK);
        wr_cfg = io_wr && hit(io_addr, `MIC_OFF_CFG);
    end

    // Event inputs gathered in the cause bit layout.
    always_comb begin
        set_vec = 16'h0000;
        set_vec[`MIC_B_HOSTF] = evt_host_bus_fault;
        set_vec[`MIC_B_TXDONE] = evt_tx_frame_done;
        set_vec[`MIC_B_CTRLF] = evt_control_frame_seen;
        set_vec[`MIC_B_RXFIFO] = evt_rx_frame_in_fifo;
        set_vec[`MIC_B_SWI] = evt_software_interrupt;
        set_vec[`MIC_B_NEAROVF] = evt_counter_near_overflow;
        set_vec[`MIC_B_LINK] = evt_link_change;
        set_vec[`MIC_B_TXDMA] = evt_tx_transfer_done;
        set_vec[`MIC_B_RXDMA] = evt_rx_transfer_done;
        set_vec[`MIC_B_MODEM] = evt_modem_line_event;
    end

    // Clear sources for the cause bits; a new event always wins.
    always_comb begin
        clr_vec = 16'h0000;
        if (rd_ack) begin
            clr_vec = clr_vec | `MIC_ACK_CLR;
        end
        if (wr_cause) begin
            clr_vec = clr_vec | (io_wdata & `MIC_CAUSE_W1C);
        end
        if (rx_dma_frame_taken) begin
            clr_vec[`MIC_B_RXFIFO] = 1'b1;
        end
    end

    always_comb begin
        st_next = st_reg;
        st_next.cause = ((st_reg.cause & ~clr_vec) | set_vec) & `MIC_CAUSE_IMPL;
        if (rd_ack) begin
            st_next.mask = 16'h0000;
        end else if (wr_mask) begin
            st_next.mask = io_wdata & `MIC_CAUSE_IMPL;
        end
        st_next.irq = |(st_next.cause & st_next.mask);
        if (wr_cfg) begin
            st_next.cfg = io_wdata & `MIC_CFG_IMPL;
            st_next.seen_tx = 1'b0;
            st_next.seen_rx = 1'b0;
        end else begin
            st_next.seen_tx = st_reg.seen_tx | tx_path_reset;
            st_next.seen_rx = st_reg.seen_rx | rx_path_reset;
        end
        if (!wr_cfg && st_next.seen_tx && st_next.seen_rx) begin
            st_next.eff_duplex = st_reg.cfg[`MIC_C_DUPLEX];
            st_next.eff_buf_lb = st_reg.cfg[`MIC_C_BUFLB];
            st_next.eff_mac_lb = st_reg.cfg[`MIC_C_MACLB];
        end
        st_next.rvalid = io_rd;
        if (rd_ack || rd_cause) begin
            st_next.rdata = cause_view(st_reg.cause, st_reg.irq);
        end else if (rd_mask) begin
            st_next.rdata = st_reg.mask;
        end else if (rd_cfg) begin
            st_next.rdata = st_reg.cfg;
        end else begin
            st_next.rdata = 16'h0000;
        end
        st_next.pause_start = rx_pause_frame_seen && st_reg.cfg[`MIC_C_PAUSE];
        st_next.pause_as_data = rx_pause_frame_seen && !st_reg.cfg[`MIC_C_PAUSE];
        st_next.crc_error = rx_crc_check_valid && rx_crc_bad;
        st_next.tx_defer = !st_next.eff_duplex;
        st_next.carrier_en = !st_next.eff_duplex;
        st_next.strip_fcs = !st_next.cfg[`MIC_C_KEEP];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    mic_oversize u_oversize (
        .clk(clk),
        .resetn(resetn),
        .long_frame_accept(st_reg.cfg[`MIC_C_LONG]),
        .rx_len_valid(rx_len_valid),
        .rx_frame_len(rx_frame_len),
        .frame_too_long_flag(frame_too_long_flag),
        .too_long_valid(too_long_valid)
    );

    assign io_rdata = st_reg.rdata;
    assign io_rdata_valid = st_reg.rvalid;
    assign interrupt_line = st_reg.irq;
    assign gap_select = st_reg.cfg[`MIC_C_GAP_HI:`MIC_C_GAP_LO];
    assign duplex_full_on = st_reg.eff_duplex;
    assign tx_defer_to_rx = st_reg.tx_defer;
    assign carrier_loss_count_en = st_reg.carrier_en;
    assign long_frame_accept = st_reg.cfg[`MIC_C_LONG];
    assign pause_honor_on = st_reg.cfg[`MIC_C_PAUSE];
    assign pause_start = st_reg.pause_start;
    assign pause_as_data = st_reg.pause_as_data;
    assign keep_checksum = st_reg.cfg[`MIC_C_KEEP];
    assign strip_checksum = st_reg.strip_fcs;
    assign crc_error = st_reg.crc_error;
    assign buffer_loopback = st_reg.eff_buf_lb;
    assign controller_side_loopback = st_reg.eff_mac_lb;

    // Checks next to the logic above.

    a_ack_read_data: assert property (@(posedge clk) disable iff (!resetn)
        (io_rd && io_addr == 8'h4A) |=>
        io_rdata_valid && io_rdata == ((($past(st_reg.cause)) & 16'h0FDE) | {15'h0000, $past(interrupt_line)}))
        else $error("ack alias read data differs from cause");

    a_ack_clears_bits: assert property (@(posedge clk) disable iff (!resetn)
        (io_rd && io_addr == 8'h4A && !evt_control_frame_seen && !evt_software_interrupt
        && !evt_link_change && !evt_tx_transfer_done && !evt_rx_transfer_done) |=>
        (st_reg.cause & 16'h0748) == 16'h0000)
        else $error("ack read left an acknowledged bit set");

    a_ack_keeps_others: assert property (@(posedge clk) disable iff (!resetn)
        (io_rd && io_addr == 8'h4A && !io_wr && !rx_dma_frame_taken) |=>
        (st_reg.cause & 16'h08B6) == (($past(st_reg.cause) & 16'h08B6) | ($past(set_vec) & 16'h08B6)))
        else $error("ack read cleared a bit outside its set");

    a_ack_event_wins: assert property (@(posedge clk) disable iff (!resetn)
        (io_rd && io_addr == 8'h4A && evt_link_change) |=> st_reg.cause[8])
        else $error("event lost during ack read");

    a_ack_clears_mask: assert property (@(posedge clk) disable iff (!resetn)
        (io_rd && io_addr == 8'h4A) |=> st_reg.mask == 16'h0000 ##1 (!interrupt_line || $past(io_wr)))
        else $error("ack read did not clear the mask");

    a_pending_is_or: assert property (@(posedge clk) disable iff (!resetn)
        interrupt_line == (|(st_reg.cause & st_reg.mask)))
        else $error("interrupt line differs from masked cause");

    a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
        io_rdata_valid |-> io_rdata[15:12] == 4'h0 && ($past(io_addr) == 8'h50 || !io_rdata[5]))
        else $error("reserved bits read non-zero");

    a_cfg_reserved: assert property (@(posedge clk) disable iff (!resetn)
        (st_reg.cfg & ~16'h0F63) == 16'h0000)
        else $error("reserved config bit stored");

    a_duplex_waits: assert property (@(posedge clk) disable iff (!resetn)
        (io_wr && io_addr == 8'h50) ##1 (!tx_path_reset [*3]) |=> $stable(duplex_full_on))
        else $error("duplex changed without tx path reset");

    a_duplex_applies: assert property (@(posedge clk) disable iff (!resetn)
        (!io_wr && st_reg.seen_tx && st_reg.seen_rx) |=>
        duplex_full_on == $past(st_reg.cfg[5]) ##0 buffer_loopback == $past(st_reg.cfg[10]))
        else $error("duplex not applied after both path resets");

    a_defer_duplex: assert property (@(posedge clk) disable iff (!resetn)
        duplex_full_on |-> !tx_defer_to_rx && !carrier_loss_count_en)
        else $error("defer or carrier count active in full duplex");

    a_pause_honor: assert property (@(posedge clk) disable iff (!resetn)
        rx_pause_frame_seen |=> (pause_start == $past(pause_honor_on)) && (pause_as_data != pause_start))
        else $error("pause frame handling ignores honour bit");

    a_crc_indep: assert property (@(posedge clk) disable iff (!resetn)
        (rx_crc_check_valid && rx_crc_bad) |=> crc_error)
        else $error("checksum error not reported");

    a_strip_keep: assert property (@(posedge clk) disable iff (!resetn)
        (io_wr && io_addr == 8'h50) |=> keep_checksum == $past(io_wdata[9]) && strip_checksum == !keep_checksum)
        else $error("checksum keep setting not taken");

    a_gap_write: assert property (@(posedge clk) disable iff (!resetn)
        (io_wr && io_addr == 8'h50) |=> gap_select == $past(io_wdata[1:0]))
        else $error("gap select not taken");

    a_rxfifo_auto: assert property (@(posedge clk) disable iff (!resetn)
        (rx_dma_frame_taken && !evt_rx_frame_in_fifo) |=> !st_reg.cause[4])
        else $error("rx frame in fifo not acknowledged by dma");

    a_w1c_cause: assert property (@(posedge clk) disable iff (!resetn)
        (io_wr && io_addr == 8'h4E && io_wdata[1] && !evt_host_bus_fault) |=> !st_reg.cause[1])
        else $error("write one did not clear cause bit");

    a_loop_mac: assert property (@(posedge clk) disable iff (!resetn)
        (!io_wr && st_reg.seen_tx && st_reg.seen_rx) |=> controller_side_loopback == $past(st_reg.cfg[11]))
        else $error("controller loopback not applied");

    a_strip_inverse: assert property (@(posedge clk) disable iff (!resetn)
        strip_checksum == !keep_checksum)
        else $error("strip and keep checksum disagree");

    a_defer_half: assert property (@(posedge clk) disable iff (!resetn)
        !duplex_full_on |-> tx_defer_to_rx && carrier_loss_count_en)
        else $error("defer or carrier count off in half duplex");

    a_long_write: assert property (@(posedge clk) disable iff (!resetn)
        (io_wr && io_addr == 8'h50) |=> long_frame_accept == $past(io_wdata[6]))
        else $error("long frame setting not taken");

    a_pause_write: assert property (@(posedge clk) disable iff (!resetn)
        (io_wr && io_addr == 8'h50) |=> pause_honor_on == $past(io_wdata[8]))
        else $error("pause honour setting not taken");

    a_cause_reserved: assert property (@(posedge clk) disable iff (!resetn)
        (st_reg.cause & ~16'h0FDE) == 16'h0000)
        else $error("reserved cause bit stored");

    a_mask_reserved: assert property (@(posedge clk) disable iff (!resetn)
        (st_reg.mask & ~16'h0FDE) == 16'h0000)
        else $error("reserved mask bit stored");

    a_rdata_idle: assert property (@(posedge clk) disable iff (!resetn)
        !io_rdata_valid |-> io_rdata == 16'h0000)
        else $error("read data not zero while idle");

    a_rvalid_pulse: assert property (@(posedge clk) disable iff (!resetn)
        io_rd |=> io_rdata_valid)
        else $error("read not answered next cycle");

    a_cause_read: assert property (@(posedge clk) disable iff (!resetn)
        (io_rd && io_addr == 8'h4E) |=>
        io_rdata == (($past(st_reg.cause) & 16'h0FDE) | {15'h0000, $past(interrupt_line)}))
        else $error("cause read data wrong");

    a_mask_write: assert property (@(posedge clk) disable iff (!resetn)
        (io_wr && !io_rd && io_addr == 8'h4C) |=> st_reg.mask == ($past(io_wdata) & 16'h0FDE))
        else $error("mask write not taken");

    a_cfg_write: assert property (@(posedge clk) disable iff (!resetn)
        (io_wr && io_addr == 8'h50) |=> st_reg.cfg == ($past(io_wdata) & 16'h0F63))
        else $error("config write not taken");

    a_maclb_waits: assert property (@(posedge clk) disable iff (!resetn)
        (io_wr && io_addr == 8'h50) ##1 (!rx_path_reset [*3]) |=> $stable(controller_side_loopback))
        else $error("controller loopback changed without rx path reset");

    a_buflb_waits: assert property (@(posedge clk) disable iff (!resetn)
        (io_wr && io_addr == 8'h50) ##1 (!rx_path_reset [*3]) |=> $stable(buffer_loopback))
        else $error("buffer loopback changed without rx path reset");

    a_cause_holds: assert property (@(posedge clk) disable iff (!resetn)
        (!io_rd && !io_wr && !rx_dma_frame_taken) |=> (st_reg.cause & $past(st_reg.cause)) == $past(st_reg.cause))
        else $error("cause bit cleared with no clear source");

    a_evt_host: assert property (@(posedge clk) disable iff (!resetn)
        evt_host_bus_fault |=> st_reg.cause[1])
        else $error("host bus fault not recorded");

    a_evt_txdone: assert property (@(posedge clk) disable iff (!resetn)
        evt_tx_frame_done |=> st_reg.cause[2])
        else $error("tx frame done not recorded");

    a_evt_rxfifo: assert property (@(posedge clk) disable iff (!resetn)
        evt_rx_frame_in_fifo |=> st_reg.cause[4])
        else $error("rx frame in fifo not recorded");

    a_evt_ctrl: assert property (@(posedge clk) disable iff (!resetn)
        evt_control_frame_seen |=> st_reg.cause[3])
        else $error("control frame event lost");

    a_evt_swi: assert property (@(posedge clk) disable iff (!resetn)
        evt_software_interrupt |=> st_reg.cause[6])
        else $error("software interrupt event lost");

    a_evt_txdma: assert property (@(posedge clk) disable iff (!resetn)
        evt_tx_transfer_done |=> st_reg.cause[9])
        else $error("tx transfer done event lost");

    a_evt_rxdma: assert property (@(posedge clk) disable iff (!resetn)
        evt_rx_transfer_done |=> st_reg.cause[10])
        else $error("rx transfer done event lost");

    a_too_long_valid: assert property (@(posedge clk) disable iff (!resetn)
        rx_len_valid |=> too_long_valid)
        else $error("oversize result not given");

endmodule // mic_top
